// ### dpxa_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef DPXA_MAP_SVH
`define DPXA_MAP_SVH
`define DPXA_AUX1_OFF       8'hA2
`define DPXA_AUXM_OFF       8'h8E
`define DPXA_DPL_OFF        8'h82
`define DPXA_DPH_OFF        8'h83
`define DPXA_P2_OFF         8'hA0
// bus byte address is four times the register index for AUX1 and AUXM
`define DPXA_BUS_AUX1       12'h288
`define DPXA_BUS_AUXM       12'h238
`define DPXA_BUS_DP0        12'h100
`define DPXA_BUS_DP1        12'h104
`define DPXA_BUS_STAT       12'h108
`define DPXA_BIT_SEL        0
`define DPXA_BIT_FLAG       3
`define DPXA_BIT_BOOT       5
`define DPXA_BIT_EXT        1
`define DPXA_BIT_XRS        2
`define DPXA_BIT_STR        5
`define DPXA_AUX1_WMASK     8'h29
`define DPXA_AUXM_WMASK     8'h3E
`define DPXA_AUXM_RST       8'h08
`define DPXA_BOOT_BASE      16'hF800
`define DPXA_LOW_TOP        8'h7F
`define DPXA_STROBE_SHORT   6
`define DPXA_STROBE_LONG    30
`define DPXA_ADDR_CYC       2
`define DPXA_HOLD_CYC       1
`endif

// ### dpxa_pkg.sv
// types for the dual pointer data memory access block
package dpxa_pkg;
  typedef enum logic [2:0] {
    DPXA_IDLE = 3'b000,
    DPXA_ADDR = 3'b001,
    DPXA_STRB = 3'b011,
    DPXA_HOLD = 3'b010
  } dpxa_state_t;

  typedef enum logic [1:0] {
    DPXA_SP_DIRECT   = 2'b00,
    DPXA_SP_INDIRECT = 2'b01,
    DPXA_SP_STACK    = 2'b10
  } dpxa_mode_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic        use_ptr;
    logic        inc_ptr;
    logic        load_ptr;
    logic [15:0] load_val;
    logic [7:0]  ri_addr;
    logic [7:0]  wdata;
  } dpxa_mov_t;

  typedef struct packed {
    logic        ale;
    logic [7:0]  p0_out;
    logic        p0_oe;
    logic [7:0]  p2_out;
    logic        p2_oe;
    logic        wr_n;
    logic        rd_n;
  } dpxa_pins_t;
endpackage

// ### dpxa_expanded_ram.sv
// on-chip expanded ram array; the hide limit is applied in dpxa_top
`timescale 1ns/1ps
module dpxa_expanded_ram
  import dpxa_pkg::*;
#(
  parameter int DEPTH = 1792
) (
  input  wire logic        clk_sys,
  input  wire logic        en,
  input  wire logic        we,
  input  wire logic [10:0] addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
    if (en) begin
      rdata <= mem[addr];
    end
  end
endmodule // dpxa_expanded_ram

// ### dpxa_top.sv
// dual data pointers, memory segment routing, external move sequencer
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// R1 - two 16-bit pointers, one active
// R2 - select bit zero picks first pointer
// R3 - boot bit maps rom at F800-FFFF
// R4 - flag bit is plain software storage
// R5 - bit two reads zero, ignores writes
// R6 - reserved bits undefined, software writes zero
// R7 - low 128 bytes direct and indirect
// R8 - upper direct is registers, indirect ram
// R9 - external select clear reaches on-chip ram
// R10 - size bits hide upper on-chip ram
// R11 - on-chip access leaves pins idle
// R12 - above size, pointer moves go external
// R13 - above 0FFh only pointer reaches ram
// R14 - register move puts 8-bit address out
// R15 - pointer move emits full 16 bits
// R16 - stack stays in internal 256 bytes
// R17 - stretch bit makes strobes 30 clocks
// R18 - size codes 256/512/768/1024/1792, default 768
// R19 - load and increment change only the selected pointer
module dpxa_top
  import dpxa_pkg::*;
#(
  parameter int EXPANDED_RAM_MAX = 1792
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire dpxa_mov_t   mov,
  input  wire logic [7:0]  seg_addr,
  input  wire dpxa_mode_t  seg_mode,
  input  wire logic [15:0] code_addr,
  input  wire logic [7:0]  p0_in,
  output dpxa_pins_t       pins,
  output logic      [7:0]  mov_rdata,
  output logic             mov_done,
  output logic             busy,
  output logic             boot_hit,
  output logic             sel_sfr,
  output logic             sel_upper,
  output logic             sel_lower,
  output logic [15:0]      active_ptr
);
`include "dpxa_map.svh"

  typedef struct packed {
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic        sel;
    logic        flag;
    logic        boot;
    logic        ext;
    logic [2:0]  xrs;
    logic        stretch;
    dpxa_state_t st;
    logic [4:0]  cnt;
    logic        wr;
    logic        use_ptr;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        expanded_ram_pend;
    dpxa_pins_t  pins;
    logic [7:0]  rdata;
    logic        done;
    logic        boot_hit;
    logic        sfr;
    logic        upper;
    logic        lower;
    logic        ph_act;
    logic        ph_wr;
    logic [11:0] ph_addr;
    logic [31:0] hrdata;
    logic        busy;
    logic [15:0] act;
  } dpxa_st_t;

  dpxa_st_t s_reg;
  dpxa_st_t s_next;
  logic [7:0]  expanded_ram_rdata;
  logic        expanded_ram_en;
  logic [10:0] expanded_ram_addr;

  // enabled on-chip size per code
  function automatic logic [11:0] expanded_ram_limit(input logic [2:0] code);
    unique case (code)
      3'b000:  expanded_ram_limit = 12'h100; // R18
      3'b001:  expanded_ram_limit = 12'h200; // R18
      3'b010:  expanded_ram_limit = 12'h300; // R18
      3'b011:  expanded_ram_limit = 12'h400; // R18
      default: expanded_ram_limit = 12'h700; // R18
    endcase
  endfunction

  function automatic logic [7:0] aux1_read(input dpxa_st_t s);
    logic [7:0] v;
    v = 8'h00; // R6 R5
    v[`DPXA_BIT_SEL]  = s.sel;
    v[`DPXA_BIT_FLAG] = s.flag;
    v[`DPXA_BIT_BOOT] = s.boot;
    aux1_read = v;
  endfunction

  function automatic logic [7:0] auxm_read(input dpxa_st_t s);
    auxm_read = {2'b00, s.stretch, s.xrs, s.ext, 1'b0};
  endfunction

  dpxa_expanded_ram #(
    .DEPTH (EXPANDED_RAM_MAX)
  ) u_expanded_ram (
    .clk_sys (clk_sys),
    .en      (expanded_ram_en),
    .we      (mov.wr),
    .addr    (expanded_ram_addr),
    .wdata   (mov.wdata),
    .rdata   (expanded_ram_rdata)
  );

  logic [15:0] mov_addr;
  logic        in_expanded_ram;
  logic [11:0] expanded_ram_lim;
  assign mov_addr  = mov.use_ptr ? (s_reg.sel ? s_reg.ptr1 : s_reg.ptr0) : {8'h00, mov.ri_addr}; // R13
  assign expanded_ram_lim  = expanded_ram_limit(s_reg.xrs); // R18
  assign in_expanded_ram   = !s_reg.ext && (mov_addr < {4'h0, expanded_ram_lim})
                     && (mov.use_ptr || mov_addr[15:8] == 8'h00); // R9 R10 R13
  assign expanded_ram_en   = mov.req && s_reg.st == DPXA_IDLE && in_expanded_ram; // R11
  assign expanded_ram_addr = mov_addr[10:0];

  always_comb begin
    logic [7:0] wv;
    logic [4:0] strobe;
    wv     = 8'h00;
    s_next = s_reg;
    strobe = s_reg.stretch ? 5'(`DPXA_STROBE_LONG - 1) : 5'(`DPXA_STROBE_SHORT - 1); // R17
    s_next.done = 1'b0;
    // segment decode for internal data space
    s_next.lower = seg_addr <= `DPXA_LOW_TOP; // R7 R16
    s_next.sfr   = seg_addr > `DPXA_LOW_TOP && seg_mode == DPXA_SP_DIRECT; // R8
    s_next.upper = seg_addr > `DPXA_LOW_TOP && seg_mode != DPXA_SP_DIRECT; // R8 R16
    s_next.boot_hit = s_reg.boot && code_addr >= `DPXA_BOOT_BASE; // R3
    // register bus, data phase completes in one cycle
    if (s_reg.ph_act && s_reg.ph_wr) begin
      wv = hwdata[7:0];
      unique case (s_reg.ph_addr)
        `DPXA_BUS_AUX1: begin
          s_next.sel  = wv[`DPXA_BIT_SEL]; // R2
          s_next.flag = wv[`DPXA_BIT_FLAG]; // R4
          s_next.boot = wv[`DPXA_BIT_BOOT]; // R3
        end
        `DPXA_BUS_AUXM: begin
          s_next.ext     = wv[`DPXA_BIT_EXT];
          s_next.xrs     = wv[`DPXA_BIT_XRS +: 3]; // R18
          s_next.stretch = wv[`DPXA_BIT_STR]; // R17
        end
        `DPXA_BUS_DP0: s_next.ptr0 = hwdata[15:0];
        `DPXA_BUS_DP1: s_next.ptr1 = hwdata[15:0];
        default: ;
      endcase
    end
    s_next.ph_act  = hsel && hready && htrans[1];
    s_next.ph_wr   = hwrite;
    s_next.ph_addr = haddr[11:0];
    s_next.hrdata  = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[11:0])
        `DPXA_BUS_AUX1: s_next.hrdata = {24'h0, aux1_read(s_reg)};
        `DPXA_BUS_AUXM: s_next.hrdata = {24'h0, auxm_read(s_reg)};
        `DPXA_BUS_DP0:  s_next.hrdata = {16'h0, s_reg.ptr0};
        `DPXA_BUS_DP1:  s_next.hrdata = {16'h0, s_reg.ptr1};
        `DPXA_BUS_STAT: s_next.hrdata = {29'h0, s_reg.st};
        default:        s_next.hrdata = 32'h0000_0000;
      endcase
    end
    // pointer load and increment act on the selected one
    if (mov.load_ptr || mov.inc_ptr) begin
      if (s_reg.sel) begin
        s_next.ptr1 = mov.load_ptr ? mov.load_val : 16'(s_reg.ptr1 + 16'h0001); // R19 R1
      end else begin
        s_next.ptr0 = mov.load_ptr ? mov.load_val : 16'(s_reg.ptr0 + 16'h0001); // R19 R1
      end
    end
    // on-chip ram returns data one cycle later
    s_next.expanded_ram_pend = expanded_ram_en;
    if (s_reg.expanded_ram_pend) begin
      s_next.rdata = expanded_ram_rdata;
      s_next.done  = 1'b1;
    end
    unique case (s_reg.st)
      DPXA_IDLE: begin
        if (mov.req && !in_expanded_ram) begin
          s_next.st      = DPXA_ADDR; // R12
          s_next.addr    = mov_addr;
          s_next.wr      = mov.wr;
          s_next.use_ptr = mov.use_ptr;
          s_next.wdata   = mov.wdata;
          s_next.cnt     = 5'(`DPXA_ADDR_CYC - 1);
          s_next.pins.ale    = 1'b1;
          s_next.pins.p0_out = mov_addr[7:0]; // R14 R15
          s_next.pins.p0_oe  = 1'b1;
          s_next.pins.p2_out = mov_addr[15:8]; // R15
          s_next.pins.p2_oe  = mov.use_ptr; // R14
        end
      end
      DPXA_ADDR: begin
        s_next.cnt = 5'(s_reg.cnt - 5'd1);
        if (s_reg.cnt == 5'd0) begin
          s_next.st          = DPXA_STRB;
          s_next.cnt         = strobe;
          s_next.pins.ale    = 1'b0;
          s_next.pins.p0_out = s_reg.wdata;
          s_next.pins.p0_oe  = s_reg.wr;
          s_next.pins.wr_n   = !s_reg.wr; // R15
          s_next.pins.rd_n   = s_reg.wr; // R15
        end
      end
      DPXA_STRB: begin
        s_next.cnt = 5'(s_reg.cnt - 5'd1);
        if (s_reg.cnt == 5'd0) begin
          s_next.st        = DPXA_HOLD;
          s_next.cnt       = 5'(`DPXA_HOLD_CYC - 1);
          s_next.pins.wr_n = 1'b1;
          s_next.pins.rd_n = 1'b1;
          if (!s_reg.wr) begin
            s_next.rdata = p0_in;
          end
        end
      end
      DPXA_HOLD: begin
        s_next.st         = DPXA_IDLE;
        s_next.done       = 1'b1;
        s_next.pins.p0_oe = 1'b0;
        s_next.pins.p2_oe = 1'b0;
      end
      default: s_next.st = DPXA_IDLE;
    endcase
    s_next.busy = s_next.st != DPXA_IDLE;
    s_next.act  = s_next.sel ? s_next.ptr1 : s_next.ptr0; // R1 R2
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_reg           <= '0;
      s_reg.xrs       <= 3'b010; // R18
      s_reg.pins.wr_n <= 1'b1;
      s_reg.pins.rd_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hrdata     = s_reg.hrdata;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign pins       = s_reg.pins;
  assign mov_rdata  = s_reg.rdata;
  assign mov_done   = s_reg.done;
  assign busy       = s_reg.busy;
  assign boot_hit   = s_reg.boot_hit;
  assign sel_sfr    = s_reg.sfr;
  assign sel_upper  = s_reg.upper;
  assign sel_lower  = s_reg.lower;
  assign active_ptr = s_reg.act;
endmodule // dpxa_top

// ### dpxa_sva.sv
// checker for dpxa_top
`timescale 1ns/1ps
module dpxa_sva
  import dpxa_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire dpxa_mov_t   mov,
  input wire logic [7:0]  seg_addr,
  input wire dpxa_mode_t  seg_mode,
  input wire logic [15:0] code_addr,
  input wire dpxa_pins_t  pins,
  input wire logic        busy,
  input wire logic        boot_hit,
  input wire logic        sel_sfr,
  input wire logic        sel_upper,
  input wire logic        sel_lower,
  input wire logic [15:0] active_ptr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [5:0] low_cnt;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= 6'h00;
    end else begin
      low_cnt <= (pins.rd_n && pins.wr_n) ? 6'h00 : 6'(low_cnt + 6'h01);
    end
  end
  low_seg_a: assert property (
    !seg_addr[7] |=> sel_lower && !sel_upper && !sel_sfr) else $error("low decode");
  sfr_seg_a: assert property (
    seg_addr[7] && seg_mode == DPXA_SP_DIRECT |=> sel_sfr && !sel_upper) else $error("sfr decode");
  up_seg_a: assert property (
    seg_addr[7] && seg_mode != DPXA_SP_DIRECT |=> sel_upper && !sel_sfr) else $error("upper decode");
  boot_off_a: assert property (code_addr < 16'hF800 |=> !boot_hit) else $error("boot");
  strobe_min_a: assert property (
    $fell(pins.rd_n) || $fell(pins.wr_n) |-> (!(pins.rd_n && pins.wr_n))[*6]) else $error("short");
  strobe_end_a: assert property (
    $rose(pins.rd_n && pins.wr_n) |-> low_cnt == 6'h06 || low_cnt == 6'h1E) else $error("strobe length");
  idle_pins_a: assert property (
    !busy && !$past(busy) |-> pins.rd_n && pins.wr_n && !pins.ale && !pins.p0_oe) else $error("idle");
  p2_hi_a: assert property (
    pins.ale && pins.p2_oe |-> pins.p2_out == active_ptr[15:8]) else $error("p2");
  load_a: assert property (mov.load_ptr |=> active_ptr == $past(mov.load_val)) else $error("load");
  inc_a: assert property (
    mov.inc_ptr && !mov.load_ptr |=> active_ptr == $past(active_ptr) + 16'h0001) else $error("inc");
  cover property ($fell(pins.rd_n));
  cover property ($fell(pins.wr_n));
  cover property (boot_hit);
endmodule // dpxa_sva

bind dpxa_top dpxa_sva u_sva (.clk_sys, .nrst, .mov, .seg_addr, .seg_mode, .code_addr, .pins, .busy,
  .boot_hit, .sel_sfr, .sel_upper, .sel_lower, .active_ptr);

// ### dpxa_extmem.sv
// external memory model on the multiplexed bus
`timescale 1ns/1ps
module dpxa_extmem
  import dpxa_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire dpxa_pins_t pins,
  input  wire logic       slow,
  output logic      [7:0] p0_in
);
  logic [7:0]  mem [0:65535];
  logic [15:0] adr = 16'h0000;
  logic [4:0]  cnt = 5'h00;
  logic        wr_q = 1'b1;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    p0_in = 8'h00;
  end
  always @(posedge clk_sys) begin
    wr_q <= pins.wr_n;
    if (pins.ale) adr <= {pins.p2_oe ? pins.p2_out : 8'h00, pins.p0_out};
    cnt <= pins.rd_n ? 5'h00 : cnt + 5'h01;
    // released bus toggles, slow device answers late
    if (!pins.rd_n && cnt >= (slow ? 5'h14 : 5'h02)) p0_in <= mem[adr];
    else p0_in <= ~p0_in;
    if (pins.wr_n && !wr_q) mem[adr] <= pins.p0_out;
  end
endmodule // dpxa_extmem

// ### dpxa_tb.sv
// bench for dpxa_top
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; $display("MISMATCH %0t got %h", $time, a); end end
module tb;
  import dpxa_pkg::*;
  logic        clk_sys, nrst, hsel, hwrite, hready, hreadyout, hresp, slow, mov_done, busy, rdph;
  logic        boot_hit, sel_sfr, sel_upper, sel_lower;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  seg_addr, p0_in, mov_rdata, d;
  logic [8:0]  m9, q_mov[$];
  logic [15:0] code_addr, active_ptr;
  logic [31:0] haddr, hwdata, hrdata, e, q_bus[$];
  dpxa_mov_t   mov;
  dpxa_mode_t  seg_mode;
  dpxa_pins_t  pins;
  int          mismatches, checks_done;
  localparam logic [31:0] aux_one_addr  = 32'h0000_0288;
  localparam logic [31:0] aux_main_addr = 32'h0000_0238;
  int          sz[5] = '{256, 512, 768, 1024, 1792};
  logic [15:0] ca[3] = '{16'hF7FF, 16'hF800, 16'hFFFF};
  logic [7:0]  sa[4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
  dpxa_top DUT (.clk_sys, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .mov, .seg_addr, .seg_mode, .code_addr, .p0_in, .pins, .mov_rdata, .mov_done, .busy, .boot_hit,
    .sel_sfr, .sel_upper, .sel_lower, .active_ptr);
  dpxa_extmem ext (.clk_sys, .pins, .slow, .p0_in);
  assign hready = hreadyout;
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (rdph) begin
      e = q_bus.pop_front();
      `CHK({hresp, hreadyout, hrdata}, {2'b01, e})
    end
    if (mov_done) begin
      m9 = q_mov.pop_front();
      if (m9[8]) `CHK(mov_rdata, m9[7:0])
    end
    rdph = hsel && htrans[1] && !hwrite && hready;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic await(input bit k);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((k ? mov_done : hready) !== 1'b1 && n < 99);
    if (n >= 99) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic ahb(input bit w, input logic [31:0] a, v);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    await(0);
    htrans <= 2'b00;
    hwdata <= v;
    await(0);
  endtask
  task automatic rd(input logic [31:0] a, x);
    q_bus.push_back(x);
    ahb(0, a, 32'h0);
  endtask
  task automatic mv(input bit w, p, input logic [7:0] ri, wd, input logic [8:0] x);
    q_mov.push_back(x);
    mov <= '{req: 1'b1, wr: w, use_ptr: p, ri_addr: ri, wdata: wd, default: '0};
    @(posedge clk_sys);
    mov <= '0;
    await(1);
  endtask
  task automatic xs(input logic [7:0] v);
    mv(1, 1, 8'h00, v, 9'h000);
    mv(0, 1, 8'h00, 8'h00, {1'b1, v});
  endtask
  task automatic pt(input bit ld, input logic [15:0] v);
    mov <= '{load_ptr: ld, inc_ptr: !ld, load_val: v, default: '0};
    @(posedge clk_sys);
    mov <= '0;
    @(posedge clk_sys);
  endtask
  initial begin
    void'($urandom(25471));
    {nrst, hsel, hwrite, htrans, hwdata, haddr, slow, rdph, code_addr, seg_addr} = '0;
    hsize = 3'h2;
    mov = '0;
    seg_mode = DPXA_SP_DIRECT;
    mismatches = 0;
    checks_done = 0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(aux_one_addr, 32'h0);
    rd(aux_main_addr, 32'h08);
    ahb(1, 32'h200, 32'hFF);
    rd(32'h200, 32'h0);
    ahb(1, aux_one_addr, 32'h2D);
    rd(aux_one_addr, 32'h29);
    for (int b = 0; b < 2; b++) begin
      ahb(1, aux_one_addr, {26'h0, b[0], 5'h00});
      foreach (ca[i]) begin
        code_addr <= ca[i];
        repeat (2) @(posedge clk_sys);
        `CHK(boot_hit, b[0] && ca[i][15:11] == 5'h1F)
      end
    end
    for (int m = 0; m < 3; m++) foreach (sa[i]) begin
      seg_mode <= dpxa_mode_t'(m);
      seg_addr <= sa[i];
      repeat (2) @(posedge clk_sys);
      `CHK({sel_lower, sel_sfr, sel_upper}, {!sa[i][7], sa[i][7] && m == 0, sa[i][7] && m != 0})
    end
    ahb(1, aux_one_addr, 32'h0);
    pt(1, 16'h1234);
    ahb(1, aux_one_addr, 32'h1);
    pt(1, 16'hABCD);
    pt(0, 16'h0000);
    `CHK(active_ptr, 16'hABCE)
    rd(32'h100, 32'h1234);
    rd(32'h104, 32'hABCE);
    ahb(1, aux_one_addr, 32'h0);
    for (int c = 0; c < 5; c++) begin
      ahb(1, aux_main_addr, {27'h0, c[2:0], 2'b00});
      d = 8'($urandom);
      pt(1, 16'(sz[c] - 1));
      xs(d);
      `CHK(ext.mem[sz[c] - 1], 8'h00)
      pt(0, 16'h0000);
      xs(~d);
      `CHK(ext.mem[sz[c]], ~d)
    end
    ahb(1, aux_main_addr, 32'h2C);
    slow <= 1'b1;
    pt(1, 16'h4321);
    d = 8'($urandom);
    xs(d);
    `CHK(ext.mem[16'h4321], d)
    slow <= 1'b0;
    ahb(1, aux_main_addr, 32'h08);
    mv(1, 0, 8'h80, 8'h5C, 9'h000);
    pt(1, 16'h0080);
    mv(0, 1, 8'h00, 8'h00, 9'h15C);
    ahb(1, aux_main_addr, 32'h0A);
    mv(1, 0, 8'h44, 8'hC3, 9'h000);
    `CHK(ext.mem[16'h0044], 8'hC3)
    mv(1, 1, 8'h00, 8'h77, 9'h000);
    `CHK(ext.mem[16'h0080], 8'h77)
    report_and_stop();
  end
endmodule // tb
